/* core/tcc_pkg.sv */
// Register map, field layout and mode codes of the 8-bit timer/counter
package tcc_pkg;
    // Register byte addresses (word aligned)
    localparam logic [7:0] ADDR_CTRL_A   = 8'h00;
    localparam logic [7:0] ADDR_CTRL_B   = 8'h04;
    localparam logic [7:0] ADDR_COUNT    = 8'h08;
    localparam logic [7:0] ADDR_CMP_A    = 8'h0C;
    localparam logic [7:0] ADDR_CMP_B    = 8'h10;
    localparam logic [7:0] ADDR_FLAGS    = 8'h14;
    localparam logic [7:0] ADDR_MASK     = 8'h18;
    localparam logic [7:0] ADDR_POWER    = 8'h1C;
    localparam logic [7:0] ADDR_SVC      = 8'h20;
    localparam logic [7:0] ADDR_OUT      = 8'h24;

    // control_reg_a: [7:6] action A, [5:4] action B, [1:0] low wave mode bits
    localparam int ACT_A_LSB  = 6;
    localparam int ACT_B_LSB  = 4;
    localparam int WAVE_LO_LSB = 0;
    // control_reg_b: [7] force A, [6] force B, [3] high wave mode bit, [2:0] tick source
    localparam int FORCE_A_BIT = 7;
    localparam int FORCE_B_BIT = 6;
    localparam int WAVE_HI_BIT = 3;
    localparam int TICK_SEL_LSB = 0;
    // Flag and mask registers: [2] match B, [1] match A, [0] overflow
    localparam int FLAG_OVF = 0;
    localparam int FLAG_MA  = 1;
    localparam int FLAG_MB  = 2;

    localparam logic [7:0] CNT_BOTTOM = 8'h00;
    localparam logic [7:0] CNT_MAX    = 8'hFF;
    localparam logic [7:0] CNT_ONE    = 8'h01;
    localparam logic [7:0] BYTE_ZERO  = 8'h00;
    localparam logic       POWER_RST  = 1'b1;

    // Wave modes
    localparam logic [2:0] WM_NORMAL   = 3'h0;
    localparam logic [2:0] WM_PC_MAX   = 3'h1;
    localparam logic [2:0] WM_CTC      = 3'h2;
    localparam logic [2:0] WM_FAST_MAX = 3'h3;
    localparam logic [2:0] WM_PC_CMP   = 3'h5;
    localparam logic [2:0] WM_FAST_CMP = 3'h7;

    // Tick sources
    localparam logic [2:0] TS_STOP  = 3'h0;
    localparam logic [2:0] TS_DIV1  = 3'h1;
    localparam logic [2:0] TS_DIV8  = 3'h2;
    localparam logic [2:0] TS_DIV64 = 3'h3;
    localparam logic [2:0] TS_DIV256 = 3'h4;
    localparam logic [2:0] TS_DIV1K = 3'h5;
    localparam logic [2:0] TS_EXT_FALL = 3'h6;
    localparam logic [2:0] TS_EXT_RISE = 3'h7;

    // Prescaler tap indices into a 10-bit free-running divider
    localparam int PS_WIDTH = 10;
    localparam int TAP_8    = 2;
    localparam int TAP_64   = 5;
    localparam int TAP_256  = 7;
    localparam int TAP_1K   = 9;

    // Output actions
    localparam logic [1:0] ACT_NONE   = 2'h0;
    localparam logic [1:0] ACT_TOGGLE = 2'h1;
    localparam logic [1:0] ACT_CLEAR  = 2'h2;
    localparam logic [1:0] ACT_SET    = 2'h3;
endpackage : tcc_pkg

/* core/tcc_tick_gen.sv */
// Timer tick generation: prescaler taps and external pin edge detection
`timescale 1ns/1ps
`default_nettype none
module tcc_tick_gen
    import tcc_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       enable_i,
    input  wire logic [2:0] tick_source_select_i,
    input  wire logic       ext_count_pin_i,
    output logic            timer_tick_o
);
    logic [PS_WIDTH-1:0] presc_r;
    logic [PS_WIDTH-1:0] presc_nxt;
    logic                ext_s1_r;
    logic                ext_s2_r;
    logic                ext_prev_r;
    logic [PS_WIDTH-1:0] wrap_pulse;

    assign presc_nxt = presc_r + PS_WIDTH'(1);
    // A tap pulses when all bits up to it roll over
    assign wrap_pulse[0] = presc_r[0];
    for (genvar i = 1; i < PS_WIDTH; i++) begin : g_wrap
        assign wrap_pulse[i] = wrap_pulse[i-1] & presc_r[i];
    end

    // Prescaler runs free of the tick selection
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            presc_r <= '0;
        end else begin
            presc_r <= presc_nxt;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ext_s1_r   <= 1'b0;
            ext_s2_r   <= 1'b0;
            ext_prev_r <= 1'b0;
        end else begin
            ext_s1_r   <= ext_count_pin_i;
            ext_s2_r   <= ext_s1_r;
            ext_prev_r <= ext_s2_r;
        end
    end

    always_comb begin
        timer_tick_o = 1'b0;
        if (enable_i) begin
            unique case (tick_source_select_i)
                TS_STOP:     timer_tick_o = 1'b0;
                TS_DIV1:     timer_tick_o = 1'b1;
                TS_DIV8:     timer_tick_o = wrap_pulse[TAP_8];
                TS_DIV64:    timer_tick_o = wrap_pulse[TAP_64];
                TS_DIV256:   timer_tick_o = wrap_pulse[TAP_256];
                TS_DIV1K:    timer_tick_o = wrap_pulse[TAP_1K];
                TS_EXT_FALL: timer_tick_o = ext_prev_r & ~ext_s2_r;
                TS_EXT_RISE: timer_tick_o = ~ext_prev_r & ext_s2_r;
            endcase
        end
    end
endmodule : tcc_tick_gen
`default_nettype wire

/* core/tcc_cmp_unit.sv */
// One compare unit: buffered compare value, match flag and wave output
`timescale 1ns/1ps
`default_nettype none
module tcc_cmp_unit
    import tcc_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic [7:0] count_i,
    input  wire logic       tick_i,
    input  wire logic       block_i,
    input  wire logic       buffered_i,
    input  wire logic       pwm_fast_i,
    input  wire logic       pwm_pc_i,
    input  wire logic       up_i,
    input  wire logic       load_i,
    input  wire logic       at_bottom_i,
    input  wire logic [1:0] action_i,
    input  wire logic       wr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       force_i,
    input  wire logic       flag_clr_i,
    output logic [7:0]      compare_o,
    output logic [7:0]      sw_view_o,
    output logic            match_o,
    output logic            flag_o,
    output logic            wave_o
);
    logic [7:0] active_r;
    logic [7:0] buffer_r;
    logic       match_set;
    logic       wave_nxt;

    assign compare_o = active_r;
    // software sees the buffer when buffered
    assign sw_view_o = buffered_i ? buffer_r : active_r;
    assign match_o   = (count_i == active_r);
    // a counter write blocks the next tick's match
    assign match_set = match_o & tick_i & ~block_i;

    // buffered values move across only at top
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            active_r <= BYTE_ZERO;
            buffer_r <= BYTE_ZERO;
        end else begin
            if (wr_i) begin
                buffer_r <= wdata_i;
            end
            if (wr_i && !buffered_i) begin
                active_r <= wdata_i;
            end else if (buffered_i && load_i) begin
                active_r <= buffer_r;
            end
        end
    end

    // write-one or service clears; set wins over clear
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            flag_o <= 1'b0;
        end else if (match_set) begin
            flag_o <= 1'b1;
        end else if (flag_clr_i) begin
            flag_o <= 1'b0;
        end
    end

    // action field used live; state kept across modes
    always_comb begin
        wave_nxt = wave_o;
        if (pwm_fast_i) begin
            if (action_i[1] && match_set) begin
                wave_nxt = action_i[0];
            end else if (action_i[1] && tick_i && at_bottom_i) begin
                wave_nxt = ~action_i[0];
            end
        end else if (pwm_pc_i) begin
            if (action_i[1] && match_set) begin
                wave_nxt = up_i ? action_i[0] : ~action_i[0];
            end
        end else if (match_set || force_i) begin
            // forced match updates only the output
            unique case (action_i)
                ACT_NONE:   wave_nxt = wave_o;
                ACT_TOGGLE: wave_nxt = ~wave_o;
                ACT_CLEAR:  wave_nxt = 1'b0;
                ACT_SET:    wave_nxt = 1'b1;
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wave_o <= 1'b0;
        end else begin
            wave_o <= wave_nxt;
        end
    end
endmodule : tcc_cmp_unit
`default_nettype wire

/* core/tcc_timer.sv */
// 8-bit timer/counter with two compare units behind an APB slave
//
// Functional notes
// - Bottom signalled when count becomes zero.
// - Max signalled when count becomes 255.
// - Top is max or compare A.
// - Each tick clears, increments or decrements.
// - Tick source zero stops the counter.
// - Count readable at any time, writable only while the power gate bit is clear.
// - Software count write beats clear/count.
// - Wave mode from control A and B.
// - Overflow flag set per mode, interruptible.
// - Match sets flag at next tick.
// - Flag cleared by service or writing one.
// - Three flags, each with mask bit.
// - Compare buffered only in PWM modes.
// - Buffer loads at top.
// - Software reaches buffer or active register.
// - Force strobe updates output outside PWM modes, no flag.
// - Count write blocks next tick's match.
// - Output state kept across mode changes.
// - Output action change acts immediately.
// - Disabled until power gate bit cleared.
// - Source one is clock; then divided taps.
// - Sources seven/six count rising/falling pin.
// - Mode 0 normal, 2 clear-on-match, 3/7 fast.
`timescale 1ns/1ps
`default_nettype none
module tcc_timer
    import tcc_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic [31:0]      prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic        ext_count_pin_i,
    input  wire logic [2:0]  irq_ack_i,
    output logic             wave_out_a_o,
    output logic             wave_out_b_o,
    output logic [2:0]       irq_o
);
    ////////////////////////////////////////////////////////////////////////
    typedef enum logic [1:0] {
        TCC_DIR_UP   = 2'b01,
        TCC_DIR_DOWN = 2'b10
    } tcc_dir_t;

    logic [7:0]  control_reg_a_r;
    logic [7:0]  control_reg_b_r;
    logic [7:0]  count_value_r;
    logic [7:0]  count_value_nxt;
    logic [2:0]  timer_flag_reg;
    logic [2:0]  timer_irq_mask_reg_r;
    logic        overflow_flag_r;
    logic        power_gate_bit_r;
    logic        block_r;
    tcc_dir_t    dir_r;
    tcc_dir_t    dir_nxt;
    logic [2:0]  wave_mode_field;
    logic [2:0]  tick_source_select;
    logic        timer_tick;
    logic        enabled;
    logic        pwm_fast;
    logic        pwm_pc;
    logic        buffered;
    logic        top_is_a;
    logic [7:0]  top_value;
    logic        at_top;
    logic        at_bottom;
    logic        at_max;
    logic        ovf_set;
    logic        load_cmp;
    logic        wr_access;
    logic        rd_access;
    logic        addr_ok;
    logic        count_wr;
    logic        force_a;
    logic        force_b;
    logic [2:0]  flag_clr;
    logic [7:0]  compare_value_a;
    logic [7:0]  sw_view_a;
    logic [7:0]  sw_view_b;
    logic        match_a;
    logic        match_b;
    logic        match_flag_a;
    logic        match_flag_b;
    logic        wave_a;
    logic        wave_b;
    logic [31:0] rdata_nxt;

    ////////////////////////////////////////////////////////////////////////
    // Bus decode; every access completes in its first access cycle
    assign wr_access = psel_i & penable_i & pwrite_i & pready_o;
    assign rd_access = psel_i & ~penable_i & ~pwrite_i;
    assign addr_ok   = (paddr_i == ADDR_CTRL_A) || (paddr_i == ADDR_CTRL_B)
                     || (paddr_i == ADDR_COUNT) || (paddr_i == ADDR_CMP_A)
                     || (paddr_i == ADDR_CMP_B) || (paddr_i == ADDR_FLAGS)
                     || (paddr_i == ADDR_MASK)  || (paddr_i == ADDR_POWER)
                     || (paddr_i == ADDR_SVC)   || (paddr_i == ADDR_OUT);

    // writes other than the power gate are dropped while gated
    assign enabled  = ~power_gate_bit_r;
    assign count_wr = wr_access & enabled & (paddr_i == ADDR_COUNT);
    assign force_a  = wr_access & enabled & (paddr_i == ADDR_CTRL_B)
                    & pwdata_i[FORCE_A_BIT] & ~pwm_fast & ~pwm_pc;
    assign force_b  = wr_access & enabled & (paddr_i == ADDR_CTRL_B)
                    & pwdata_i[FORCE_B_BIT] & ~pwm_fast & ~pwm_pc;
    assign flag_clr = irq_ack_i
                    | ({3{wr_access & enabled & (paddr_i == ADDR_FLAGS)}} & pwdata_i[2:0]);

    ////////////////////////////////////////////////////////////////////////
    // mode split across both control registers
    assign wave_mode_field    = {control_reg_b_r[WAVE_HI_BIT],
                                 control_reg_a_r[WAVE_LO_LSB +: 2]};
    assign tick_source_select = control_reg_b_r[TICK_SEL_LSB +: 3];
    assign pwm_fast = (wave_mode_field == WM_FAST_MAX) || (wave_mode_field == WM_FAST_CMP);
    assign pwm_pc   = (wave_mode_field == WM_PC_MAX) || (wave_mode_field == WM_PC_CMP);
    assign buffered = pwm_fast | pwm_pc;
    assign top_is_a  = (wave_mode_field == WM_CTC) || (wave_mode_field == WM_FAST_CMP)
                     || (wave_mode_field == WM_PC_CMP);
    assign top_value = top_is_a ? compare_value_a : CNT_MAX;
    assign at_bottom = (count_value_r == CNT_BOTTOM);
    assign at_max    = (count_value_r == CNT_MAX);
    assign at_top    = (count_value_r == top_value);

    tcc_tick_gen u_tick (
        .clk_i                (clk_i),
        .rst_i                (rst_i),
        .enable_i             (enabled),
        .tick_source_select_i (tick_source_select),
        .ext_count_pin_i      (ext_count_pin_i),
        .timer_tick_o         (timer_tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // per-mode next count and direction
    always_comb begin
        count_value_nxt = count_value_r;
        dir_nxt         = dir_r;
        ovf_set         = 1'b0;
        load_cmp        = 1'b0;
        if (timer_tick) begin
            if (pwm_pc) begin
                if (dir_r == TCC_DIR_UP && at_top) begin
                    dir_nxt         = TCC_DIR_DOWN;
                    count_value_nxt = count_value_r - CNT_ONE;
                    load_cmp        = 1'b1;
                end else if (dir_r == TCC_DIR_DOWN && at_bottom) begin
                    dir_nxt         = TCC_DIR_UP;
                    count_value_nxt = count_value_r + CNT_ONE;
                    ovf_set         = 1'b1;
                end else if (dir_r == TCC_DIR_UP) begin
                    count_value_nxt = count_value_r + CNT_ONE;
                end else begin
                    count_value_nxt = count_value_r - CNT_ONE;
                end
            end else if (top_is_a && at_top) begin
                count_value_nxt = CNT_BOTTOM;
                dir_nxt         = TCC_DIR_UP;
                // fast PWM flags at top, CTC at wrap past max
                ovf_set         = pwm_fast;
                load_cmp        = pwm_fast;
            end else begin
                count_value_nxt = count_value_r + CNT_ONE;
                dir_nxt         = TCC_DIR_UP;
                ovf_set         = at_max;
                load_cmp        = pwm_fast & at_max;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            count_value_r <= CNT_BOTTOM;
            dir_r         <= TCC_DIR_UP;
        end else if (count_wr) begin
            count_value_r <= pwdata_i[7:0];
        end else begin
            count_value_r <= count_value_nxt;
            dir_r         <= dir_nxt;
        end
    end

    // block held until the next tick, even when stopped
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            block_r <= 1'b0;
        end else if (count_wr) begin
            block_r <= 1'b1;
        end else if (timer_tick) begin
            block_r <= 1'b0;
        end
    end

    // overflow flag, set wins over clear
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            overflow_flag_r <= 1'b0;
        end else if (ovf_set) begin
            overflow_flag_r <= 1'b1;
        end else if (flag_clr[FLAG_OVF]) begin
            overflow_flag_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Compare units A and B
    tcc_cmp_unit u_cmp_a (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .count_i     (count_value_r),
        .tick_i      (timer_tick),
        .block_i     (block_r),
        .buffered_i  (buffered),
        .pwm_fast_i  (pwm_fast),
        .pwm_pc_i    (pwm_pc),
        .up_i        (dir_r == TCC_DIR_UP),
        .load_i      (load_cmp),
        .at_bottom_i (at_max | at_top),
        .action_i    (control_reg_a_r[ACT_A_LSB +: 2]),
        .wr_i        (wr_access & enabled & (paddr_i == ADDR_CMP_A)),
        .wdata_i     (pwdata_i[7:0]),
        .force_i     (force_a),
        .flag_clr_i  (flag_clr[FLAG_MA]),
        .compare_o   (compare_value_a),
        .sw_view_o   (sw_view_a),
        .match_o     (match_a),
        .flag_o      (match_flag_a),
        .wave_o      (wave_a)
    );

    tcc_cmp_unit u_cmp_b (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .count_i     (count_value_r),
        .tick_i      (timer_tick),
        .block_i     (block_r),
        .buffered_i  (buffered),
        .pwm_fast_i  (pwm_fast),
        .pwm_pc_i    (pwm_pc),
        .up_i        (dir_r == TCC_DIR_UP),
        .load_i      (load_cmp),
        .at_bottom_i (at_max | at_top),
        .action_i    (control_reg_a_r[ACT_B_LSB +: 2]),
        .wr_i        (wr_access & enabled & (paddr_i == ADDR_CMP_B)),
        .wdata_i     (pwdata_i[7:0]),
        .force_i     (force_b),
        .flag_clr_i  (flag_clr[FLAG_MB]),
        .compare_o   (),
        .sw_view_o   (sw_view_b),
        .match_o     (match_b),
        .flag_o      (match_flag_b),
        .wave_o      (wave_b)
    );

    assign timer_flag_reg = {match_flag_b, match_flag_a, overflow_flag_r};

    ////////////////////////////////////////////////////////////////////////
    // Control, mask and power registers; force bits are strobes only
    // reset zeroes fields
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            control_reg_a_r      <= BYTE_ZERO;
            control_reg_b_r      <= BYTE_ZERO;
            timer_irq_mask_reg_r <= '0;
        end else if (wr_access && enabled) begin
            if (paddr_i == ADDR_CTRL_A) begin
                control_reg_a_r <= pwdata_i[7:0];
            end
            if (paddr_i == ADDR_CTRL_B) begin
                control_reg_b_r <= {2'b00, pwdata_i[5:0]};
            end
            if (paddr_i == ADDR_MASK) begin
                timer_irq_mask_reg_r <= pwdata_i[2:0];
            end
        end
    end

    // gate bit starts set, so the timer sleeps until cleared
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            power_gate_bit_r <= POWER_RST;
        end else if (wr_access && paddr_i == ADDR_POWER) begin
            power_gate_bit_r <= pwdata_i[0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read mux
    always_comb begin
        rdata_nxt = '0;
        unique case (paddr_i)
            ADDR_CTRL_A: rdata_nxt[7:0] = control_reg_a_r;
            ADDR_CTRL_B: rdata_nxt[7:0] = control_reg_b_r;
            ADDR_COUNT:  rdata_nxt[7:0] = count_value_r;
            ADDR_CMP_A:  rdata_nxt[7:0] = sw_view_a;
            ADDR_CMP_B:  rdata_nxt[7:0] = sw_view_b;
            ADDR_FLAGS:  rdata_nxt[2:0] = timer_flag_reg;
            ADDR_MASK:   rdata_nxt[2:0] = timer_irq_mask_reg_r;
            ADDR_POWER:  rdata_nxt[0]   = power_gate_bit_r;
            ADDR_SVC:    rdata_nxt[3:0] = {match_b, match_a, at_top, at_bottom};
            ADDR_OUT:    rdata_nxt[1:0] = {wave_b, wave_a};
            default:     rdata_nxt      = '0;
        endcase
    end

    // Ready answers one cycle after the setup phase, then drops
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pready_o  <= 1'b0;
            prdata_o  <= '0;
            pslverr_o <= 1'b0;
        end else begin
            pready_o  <= psel_i & ~penable_i;
            pslverr_o <= psel_i & ~penable_i & ~addr_ok;
            if (rd_access) begin
                prdata_o <= rdata_nxt;
            end
        end
    end

    // Outputs registered; request levels follow flag and mask
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wave_out_a_o <= 1'b0;
            wave_out_b_o <= 1'b0;
            irq_o        <= '0;
        end else begin
            wave_out_a_o <= wave_a;
            wave_out_b_o <= wave_b;
            irq_o        <= timer_flag_reg & timer_irq_mask_reg_r & ~irq_ack_i;
        end
    end
endmodule : tcc_timer
`default_nettype wire

/* testbench/tcc_timer_monitor.sv */
// Bus handshake and reset checks for the timer/counter
`timescale 1ns/1ps
`default_nettype none
module tcc_timer_monitor
    import tcc_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [7:0]  paddr_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input wire logic        wave_out_a_o,
    input wire logic [2:0]  irq_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ready_after_setup: assert property (psel_i && !penable_i |=> pready_o)
        else $error("ready missing");
    a_ready_one_cycle: assert property (pready_o |=> !pready_o)
        else $error("ready too long");
    a_ready_cause: assert property (pready_o |-> $past(psel_i && !penable_i))
        else $error("ready without setup");
    a_err_unmapped: assert property (pready_o && paddr_i > ADDR_OUT |-> pslverr_o)
        else $error("unmapped accepted");
    a_err_mapped: assert property (
        pready_o && paddr_i <= ADDR_OUT && paddr_i[1:0] == 2'b00 |-> !pslverr_o)
        else $error("mapped refused");
    a_err_with_ready: assert property (pslverr_o |-> pready_o)
        else $error("lone error");
    a_rdata_hold: assert property (!$stable(prdata_o) |-> $past(psel_i && !pwrite_i))
        else $error("read data moved");
    a_reset_quiet: assert property ($fell(rst_i) |-> irq_o == 3'h0 && !wave_out_a_o)
        else $error("outputs live after reset");
endmodule : tcc_timer_monitor
bind tcc_timer tcc_timer_monitor u_monitor (.clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .prdata_o, .pready_o, .pslverr_o, .wave_out_a_o, .irq_o);
`default_nettype wire

/* testbench/test_tcc_timer.sv */
// Register-level bench for the timer/counter
`timescale 1ns/1ps
`default_nettype none
module test_tcc_timer;
    import tcc_pkg::*;
    logic clk_i = 1'b0, rst_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic [7:0] paddr_i = '0;
    logic [31:0] pwdata_i = '0, prdata_o, rd;
    logic [2:0] ack = '0, irq_o;
    logic pin = 1'b0, pready_o, pslverr_o, wa, wb, err;
    int miscompares = 0, comparisons = 0;
    tcc_timer DUT (.clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
        .prdata_o, .pready_o, .pslverr_o, .ext_count_pin_i(pin), .irq_ack_i(ack),
        .wave_out_a_o(wa), .wave_out_b_o(wb), .irq_o);
    initial begin
        forever #2 clk_i = ~clk_i;
    end
    task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask : check
    task automatic close_out;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : close_out
    // Answer is taken at the edge where pready is seen high
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do @(posedge clk_i); while (pready_o !== 1'b1);
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask : xfer
    task automatic w(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask : w
    task automatic r(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, '0);
        check($sformatf("reg %h", a), rd, e);
    endtask : r
    initial begin
        repeat (4000) @(posedge clk_i);
        miscompares++;
        close_out();
    end
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        r(ADDR_POWER, 32'h1);
        w(ADDR_COUNT, 32'h5);
        for (int i = 0; i < 7; i++) r(8'(4 * i), 32'h0);
        w(ADDR_POWER, 32'h0);
        w(ADDR_COUNT, 32'h2A);
        repeat (20) @(posedge clk_i);
        r(ADDR_COUNT, 32'h2A);
        xfer(1'b0, 8'h30, '0);
        check("unmapped error", {31'h0, err}, 32'h1);
        w(ADDR_MASK, 32'h7);
        w(ADDR_COUNT, 32'hF0);
        w(ADDR_CTRL_B, 32'(TS_DIV1));
        repeat (40) @(posedge clk_i);
        w(ADDR_CTRL_B, 32'h0);
        r(ADDR_FLAGS, 32'h7);
        check("irq", 32'(irq_o), 32'h7);
        w(ADDR_MASK, 32'h1);
        repeat (2) @(negedge clk_i);
        check("irq masked", 32'(irq_o), 32'h1);
        w(ADDR_FLAGS, 32'h1);
        r(ADDR_FLAGS, 32'h6);
        @(posedge clk_i);
        ack <= 3'b010;
        @(posedge clk_i);
        ack <= 3'b000;
        r(ADDR_FLAGS, 32'h4);
        w(ADDR_CTRL_A, 32'(WM_CTC));
        w(ADDR_CMP_A, 32'h10);
        w(ADDR_CMP_B, 32'h5);
        // First pass starts on the match value and must lose it
        for (int i = 0; i < 2; i++) begin
            w(ADDR_FLAGS, 32'h7);
            w(ADDR_COUNT, 32'(5 - 2 * i));
            w(ADDR_CTRL_B, 32'(TS_DIV1));
            repeat (4) @(posedge clk_i);
            w(ADDR_CTRL_B, 32'h0);
            r(ADDR_FLAGS, 32'(4 * i));
        end
        w(ADDR_FLAGS, 32'h7);
        w(ADDR_CTRL_A, 32'h42);
        w(ADDR_CTRL_B, 32'h80);
        r(ADDR_OUT, 32'h1);
        check("wave a", 32'(wa), 32'h1);
        check("wave b", 32'(wb), 32'h0);
        r(ADDR_FLAGS, 32'h0);
        w(ADDR_CTRL_A, 32'h43);
        r(ADDR_OUT, 32'h1);
        w(ADDR_CTRL_A, 32'h0);
        for (int s = 6; s < 8; s++) begin
            w(ADDR_COUNT, 32'h0);
            w(ADDR_CTRL_B, 32'(s));
            repeat (6) begin
                repeat (4) @(posedge clk_i);
                pin <= ~pin;
            end
            repeat (6) @(posedge clk_i);
            w(ADDR_CTRL_B, 32'h0);
            r(ADDR_COUNT, 32'h3);
        end
        // Fast PWM: compare write parks in the buffer until top
        w(ADDR_CTRL_A, 32'(WM_FAST_MAX));
        w(ADDR_CMP_A, 32'h3);
        r(ADDR_CMP_A, 32'h3);
        r(ADDR_SVC, 32'h0);
        w(ADDR_COUNT, 32'hFE);
        w(ADDR_CTRL_B, 32'(TS_DIV1));
        repeat (4) @(posedge clk_i);
        w(ADDR_CTRL_B, 32'h0);
        r(ADDR_FLAGS, 32'h3);
        r(ADDR_SVC, 32'h8);
        close_out();
    end
endmodule : test_tcc_timer
`default_nettype wire
